/* verilog/gpp_ports.sv */
// Top of the four-port GPIO block with port A wake-up
`timescale 1ns/1ps

// Functional notes
// - Four ports A-D with registers at fixed data-memory locations.
// - Input pins read live at the read cycle, no input latch.
// - Output data latch keeps its value until written again.
// - Each pin has a pull-up enable bit; 1 connects, 0 disconnects.
// - Pull-up acts only while the pin is an input.
// - Falling edge on enabled port A pin raises a wake request.
// - Wake enable acts only for input pins during idle or sleep.
// - Port A wake enable register holds one bit per pin, 7 to 0.
// - Port D bit 7 unimplemented in data, direction, pull-up; reads zero.
// - Direction 1 makes an input, 0 a CMOS output from the latch.
// - Reading an output pin returns the latch, not the pin level.
module gpp_ports (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [gpp_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [gpp_pkg::DATA_W-1:0] mem_wdata,
  output logic [gpp_pkg::DATA_W-1:0] mem_rdata,
  input wire logic [gpp_pkg::PORT_W-1:0] pa_in,
  output logic [gpp_pkg::PORT_W-1:0] pa_out,
  output logic [gpp_pkg::PORT_W-1:0] pa_oe,
  output logic [gpp_pkg::PORT_W-1:0] pa_pullup,
  input wire logic [gpp_pkg::PORT_W-1:0] pb_in,
  output logic [gpp_pkg::PORT_W-1:0] pb_out,
  output logic [gpp_pkg::PORT_W-1:0] pb_oe,
  output logic [gpp_pkg::PORT_W-1:0] pb_pullup,
  input wire logic [gpp_pkg::PORT_W-1:0] pc_in,
  output logic [gpp_pkg::PORT_W-1:0] pc_out,
  output logic [gpp_pkg::PORT_W-1:0] pc_oe,
  output logic [gpp_pkg::PORT_W-1:0] pc_pullup,
  input wire logic [gpp_pkg::PORT_D_W-1:0] pd_in,
  output logic [gpp_pkg::PORT_D_W-1:0] pd_out,
  output logic [gpp_pkg::PORT_D_W-1:0] pd_oe,
  output logic [gpp_pkg::PORT_D_W-1:0] pd_pullup,
  input wire logic core_standby,
  output logic wake_req
);
  import gpp_pkg::*;

  // All checks below run on the system clock and sleep during reset
  default clocking main_cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  gpp_port_if if_a ();
  gpp_port_if if_b ();
  gpp_port_if if_c ();
  gpp_port_if if_d ();

  logic [7:0] port_a_wake_enable_reg;
  logic [7:0] pa_sync1_reg;
  logic [7:0] pa_sync2_reg;
  logic [7:0] pa_prev_reg;
  logic [7:0] pa_fall;
  logic [7:0] pa_wake_hit;
  logic wake_req_reg;
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;
  logic [7:0] live_a;
  logic [7:0] live_b;
  logic [7:0] live_c;
  logic [7:0] live_d;

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------

  // Strobes per register, one cycle with mem_wr
  assign if_a.wr_data = mem_wr && (mem_addr == OFS_PORT_A_DATA);
  assign if_a.wr_dir = mem_wr && (mem_addr == OFS_PORT_A_DIRECTION);
  assign if_a.wr_pu = mem_wr && (mem_addr == OFS_PORT_A_PULLUP_ENABLE);
  assign if_b.wr_data = mem_wr && (mem_addr == OFS_PORT_B_DATA);
  assign if_b.wr_dir = mem_wr && (mem_addr == OFS_PORT_B_DIRECTION);
  assign if_b.wr_pu = mem_wr && (mem_addr == OFS_PORT_B_PULLUP_ENABLE);
  assign if_c.wr_data = mem_wr && (mem_addr == OFS_PORT_C_DATA);
  assign if_c.wr_dir = mem_wr && (mem_addr == OFS_PORT_C_DIRECTION);
  assign if_c.wr_pu = mem_wr && (mem_addr == OFS_PORT_C_PULLUP_ENABLE);
  assign if_d.wr_data = mem_wr && (mem_addr == OFS_PORT_D_DATA);
  assign if_d.wr_dir = mem_wr && (mem_addr == OFS_PORT_D_DIRECTION);
  assign if_d.wr_pu = mem_wr && (mem_addr == OFS_PORT_D_PULLUP_ENABLE);

  // Shared write data
  assign if_a.wdata = mem_wdata;
  assign if_b.wdata = mem_wdata;
  assign if_c.wdata = mem_wdata;
  assign if_d.wdata = mem_wdata;

  // ----------------------------------------------------------------------
  // Port slices
  // ----------------------------------------------------------------------
  gpp_port #(.W(PORT_W)) u_port_a (
    .clock(clock),
    .arst_n(arst_n),
    .regs(if_a.port),
    .pin_out(pa_out),
    .pin_oe(pa_oe),
    .pullup_on(pa_pullup)
  );

  gpp_port #(.W(PORT_W)) u_port_b (
    .clock(clock),
    .arst_n(arst_n),
    .regs(if_b.port),
    .pin_out(pb_out),
    .pin_oe(pb_oe),
    .pullup_on(pb_pullup)
  );

  gpp_port #(.W(PORT_W)) u_port_c (
    .clock(clock),
    .arst_n(arst_n),
    .regs(if_c.port),
    .pin_out(pc_out),
    .pin_oe(pc_oe),
    .pullup_on(pc_pullup)
  );

  gpp_port #(.W(PORT_D_W)) u_port_d (
    .clock(clock),
    .arst_n(arst_n),
    .regs(if_d.port),
    .pin_out(pd_out),
    .pin_oe(pd_oe),
    .pullup_on(pd_pullup)
  );

  // ----------------------------------------------------------------------
  // Wake enable register
  // ----------------------------------------------------------------------

  // One enable bit per port A pin
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      port_a_wake_enable_reg <= RST_WAKE;
    end else if (mem_wr && (mem_addr == OFS_PORT_A_WAKE_ENABLE)) begin
      port_a_wake_enable_reg <= mem_wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------

  // Inputs show the pin, outputs show the latch
  assign live_a = (if_a.dir_q & pa_in) | (~if_a.dir_q & if_a.data_q);
  assign live_b = (if_b.dir_q & pb_in) | (~if_b.dir_q & if_b.data_q);
  assign live_c = (if_c.dir_q & pc_in) | (~if_c.dir_q & if_c.data_q);
  assign live_d = (if_d.dir_q & 8'(pd_in)) | (~if_d.dir_q & if_d.data_q);

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (mem_addr)
      OFS_PORT_A_DATA: rdata_next = live_a;
      OFS_PORT_A_DIRECTION: rdata_next = if_a.dir_q;
      OFS_PORT_A_PULLUP_ENABLE: rdata_next = if_a.pu_q;
      OFS_PORT_A_WAKE_ENABLE: rdata_next = port_a_wake_enable_reg;
      OFS_PORT_B_DATA: rdata_next = live_b;
      OFS_PORT_B_DIRECTION: rdata_next = if_b.dir_q;
      OFS_PORT_B_PULLUP_ENABLE: rdata_next = if_b.pu_q;
      OFS_PORT_C_DATA: rdata_next = live_c;
      OFS_PORT_C_DIRECTION: rdata_next = if_c.dir_q;
      OFS_PORT_C_PULLUP_ENABLE: rdata_next = if_c.pu_q;
      OFS_PORT_D_DATA: rdata_next = live_d;
      OFS_PORT_D_DIRECTION: rdata_next = if_d.dir_q;
      OFS_PORT_D_PULLUP_ENABLE: rdata_next = if_d.pu_q;
      default: rdata_next = 8'h00;
    endcase
  end

  // Pins sampled on the read edge, held until the next read
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= RST_RDATA;
    end else if (mem_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  assign mem_rdata = rdata_reg;

  // ----------------------------------------------------------------------
  // Port A wake-up
  // ----------------------------------------------------------------------

  // Two-stage synchroniser then edge history
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pa_sync1_reg <= 8'hFF;
      pa_sync2_reg <= 8'hFF;
      pa_prev_reg <= 8'hFF;
    end else begin
      pa_sync1_reg <= pa_in;
      pa_sync2_reg <= pa_sync1_reg;
      pa_prev_reg <= pa_sync2_reg;
    end
  end

  // High-to-low on an enabled input pin
  assign pa_fall = pa_prev_reg & ~pa_sync2_reg;
  assign pa_wake_hit = pa_fall & port_a_wake_enable_reg & if_a.dir_q;

  // Registered wake request, only in idle or sleep
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wake_req_reg <= 1'b0;
    end else begin
      wake_req_reg <= core_standby && (|pa_wake_hit);
    end
  end

  assign wake_req = wake_req_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------

  // Port latches and pin drive
  data_hold_a: assert property (
    !if_a.wr_data |=> $stable(pa_out))
    else $error("port A latch changed without a write");

  data_take_a: assert property (
    if_a.wr_data |=> (pa_out == $past(mem_wdata)))
    else $error("port A latch did not take write data");

  data_write_a: assert property (
    if_b.wr_data |=> (pb_out == $past(mem_wdata)))
    else $error("port B latch did not take write data");

  pullup_gate_a: assert property (
    (pc_pullup & pc_oe) == 8'h00)
    else $error("pull-up on while pin drives");

  // Register reads and direction drive
  pd_top_zero_a: assert property (
    mem_rd && (mem_addr == OFS_PORT_D_DIRECTION) |=> !mem_rdata[7])
    else $error("port D bit 7 read back as one");

  pd_data_zero_a: assert property (
    mem_rd && (mem_addr == OFS_PORT_D_DATA) |=> !mem_rdata[7])
    else $error("port D data bit 7 read back as one");

  read_input_a: assert property (
    mem_rd && (mem_addr == OFS_PORT_A_DATA) && (if_a.dir_q == 8'hFF)
    |=> mem_rdata == $past(pa_in))
    else $error("input read did not return pin levels");

  read_output_a: assert property (
    mem_rd && (mem_addr == OFS_PORT_B_DATA) && (if_b.dir_q == 8'h00)
    |=> mem_rdata == $past(pb_out))
    else $error("output read did not return latch");

  rdata_hold_a: assert property (
    !mem_rd |=> $stable(mem_rdata))
    else $error("read data changed without a read");

  unmapped_zero_a: assert property (
    mem_rd && (mem_addr == 8'h07) |=> mem_rdata == 8'h00)
    else $error("unmapped location did not read zero");

  dir_drive_a: assert property (
    if_c.wr_dir |=> (pc_oe == ~$past(mem_wdata)))
    else $error("direction write did not set drive enables");

  // Port A wake-up, then read side effects, pull-up write and register map
  wake_fall_a: assert property (
    core_standby && if_a.dir_q[0] && port_a_wake_enable_reg[0]
    && $fell(pa_sync2_reg[0]) |=> wake_req)
    else $error("falling edge on enabled pin gave no wake");

  wake_quiet_a: assert property (
    !$past(core_standby) |-> !wake_req)
    else $error("wake request outside standby");

  wake_off_a: assert property (
    !(|pa_wake_hit) |=> !wake_req)
    else $error("wake request without a qualified edge");

  wake_write_a: assert property (
    mem_wr && (mem_addr == OFS_PORT_A_WAKE_ENABLE)
    |=> port_a_wake_enable_reg == $past(mem_wdata))
    else $error("wake enable write lost");

  read_no_effect_a: assert property (
    mem_rd && !mem_wr |=> $stable(pa_out) && $stable(pa_oe))
    else $error("read disturbed port state");

  pullup_write_a: assert property (
    if_a.wr_pu |=> pa_pullup == ($past(mem_wdata) & if_a.dir_q))
    else $error("pull-up enable write not applied");

  map_decode_a: assert property (
    mem_rd && (mem_addr == OFS_PORT_C_DIRECTION) |=> mem_rdata == ~$past(pc_oe))
    else $error("direction register not at its location");

endmodule

/* verilog/gpp_pkg.sv */
// Package of constants for the four-port GPIO block with pull-ups and wake
package gpp_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PORT_W = 8;
  localparam int PORT_D_W = 7;

  // ----------------------------------------------------------------------
  // Register locations in special-purpose data memory
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_PORT_A_DATA = 8'h00;
  localparam logic [7:0] OFS_PORT_A_DIRECTION = 8'h01;
  localparam logic [7:0] OFS_PORT_A_PULLUP_ENABLE = 8'h02;
  localparam logic [7:0] OFS_PORT_A_WAKE_ENABLE = 8'h03;
  localparam logic [7:0] OFS_PORT_B_DATA = 8'h04;
  localparam logic [7:0] OFS_PORT_B_DIRECTION = 8'h05;
  localparam logic [7:0] OFS_PORT_B_PULLUP_ENABLE = 8'h06;
  localparam logic [7:0] OFS_PORT_C_DATA = 8'h08;
  localparam logic [7:0] OFS_PORT_C_DIRECTION = 8'h09;
  localparam logic [7:0] OFS_PORT_C_PULLUP_ENABLE = 8'h0A;
  localparam logic [7:0] OFS_PORT_D_DATA = 8'h0C;
  localparam logic [7:0] OFS_PORT_D_DIRECTION = 8'h0D;
  localparam logic [7:0] OFS_PORT_D_PULLUP_ENABLE = 8'h0E;

  // ----------------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_DATA = 8'hFF;
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_PULLUP = 8'h00;
  localparam logic [7:0] RST_WAKE = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

endpackage

/* verilog/gpp_port_if.sv */
// Carrier between the register decoder and one port slice
`timescale 1ns/1ps
interface gpp_port_if;
  logic wr_data;
  logic wr_dir;
  logic wr_pu;
  logic [7:0] wdata;
  logic [7:0] data_q;
  logic [7:0] dir_q;
  logic [7:0] pu_q;

  // Decoder side drives strobes and write data
  modport ctrl (
    output wr_data,
    output wr_dir,
    output wr_pu,
    output wdata,
    input data_q,
    input dir_q,
    input pu_q
  );

  // Port slice side holds the registers
  modport port (
    input wr_data,
    input wr_dir,
    input wr_pu,
    input wdata,
    output data_q,
    output dir_q,
    output pu_q
  );
endinterface

/* verilog/gpp_port.sv */
// One GPIO port slice: data latch, direction and pull-up enable
`timescale 1ns/1ps
module gpp_port #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic arst_n,
  gpp_port_if.port regs,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] pullup_on
);
  import gpp_pkg::*;

  logic [W-1:0] data_reg;
  logic [W-1:0] dir_reg;
  logic [W-1:0] pu_reg;

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------

  // Output latch holds until rewritten
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      data_reg <= RST_DATA[W-1:0];
    end else if (regs.wr_data) begin
      data_reg <= regs.wdata[W-1:0];
    end
  end

  // Direction select, 1 is input
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dir_reg <= RST_DIRECTION[W-1:0];
    end else if (regs.wr_dir) begin
      dir_reg <= regs.wdata[W-1:0];
    end
  end

  // Pull-up enable per pin
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pu_reg <= RST_PULLUP[W-1:0];
    end else if (regs.wr_pu) begin
      pu_reg <= regs.wdata[W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------

  // Unused upper bits read as zero
  assign regs.data_q = 8'(data_reg);
  assign regs.dir_q = 8'(dir_reg);
  assign regs.pu_q = 8'(pu_reg);

  // Cleared direction bit drives the latch out
  assign pin_out = data_reg;
  assign pin_oe = ~dir_reg;
  // Pull-up only while the pin is an input
  assign pullup_on = pu_reg & dir_reg;

endmodule

/* bench/gpp_pin_model.sv */
// Model of the switches and circuits that sit on one port's pins
`timescale 1ns/1ps
module gpp_pin_model #(
  parameter int W = 8
) (
  input wire logic clock,
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] pin_pullup,
  input wire logic [W-1:0] ext_drv,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin_in
);
  logic toggle_reg = 1'b0;

  // Floating pins wander, so they never hold a trustworthy level
  always @(negedge clock) begin
    toggle_reg <= ~toggle_reg;
  end

  // External driver wins (contention case), then the port, then pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (ext_drv[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (pin_pullup[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = toggle_reg ^ i[0];
      end
    end
  end
endmodule

/* bench/gpp_ports_bench.sv */
// Self-checking bench for the four-port GPIO block
`timescale 1ns/1ps
module gpp_ports_bench;
  import gpp_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] mem_addr = 8'h00;
  logic mem_wr = 1'b0;
  logic mem_rd = 1'b0;
  logic [7:0] mem_wdata = 8'h00;
  logic [7:0] mem_rdata;
  logic core_standby = 1'b0;
  logic wake_req;
  logic [7:0] pa_in, pa_out, pa_oe, pa_pu, a_drv = 8'h00, a_val = 8'h00;
  logic [7:0] pb_in, pb_out, pb_oe, pb_pu, b_drv = 8'h00, b_val = 8'h00;
  logic [7:0] pc_in, pc_out, pc_oe, pc_pu, c_drv = 8'h00, c_val = 8'h00;
  logic [6:0] pd_in, pd_out, pd_oe, pd_pu, d_drv = 7'h00, d_val = 7'h00;
  logic [7:0] rd;
  int n_fail = 0;
  int checked = 0;
  localparam logic [7:0] ADR [9] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h06,
    8'h09, 8'h0A, 8'h0D, 8'h0E};
  localparam logic [7:0] RV [9] = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00,
    8'hFF, 8'h00, 8'h7F, 8'h00};

  // Clock
  always #20 clock = ~clock;

  gpp_ports dut (.clock(clock), .arst_n(arst_n), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
    .pa_pullup(pa_pu), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
    .pb_pullup(pb_pu), .pc_in(pc_in), .pc_out(pc_out), .pc_oe(pc_oe),
    .pc_pullup(pc_pu), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe),
    .pd_pullup(pd_pu), .core_standby(core_standby), .wake_req(wake_req));
  gpp_pin_model #(.W(8)) pins_a (.clock(clock), .pin_out(pa_out),
    .pin_oe(pa_oe), .pin_pullup(pa_pu), .ext_drv(a_drv), .ext_val(a_val),
    .pin_in(pa_in));
  gpp_pin_model #(.W(8)) pins_b (.clock(clock), .pin_out(pb_out),
    .pin_oe(pb_oe), .pin_pullup(pb_pu), .ext_drv(b_drv), .ext_val(b_val),
    .pin_in(pb_in));
  gpp_pin_model #(.W(8)) pins_c (.clock(clock), .pin_out(pc_out),
    .pin_oe(pc_oe), .pin_pullup(pc_pu), .ext_drv(c_drv), .ext_val(c_val),
    .pin_in(pc_in));
  gpp_pin_model #(.W(7)) pins_d (.clock(clock), .pin_out(pd_out),
    .pin_oe(pd_oe), .pin_pullup(pd_pu), .ext_drv(d_drv), .ext_val(d_val),
    .pin_in(pd_in));

  // Compare one value
  task automatic check(input string name, input logic [7:0] seen,
    input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // One-cycle write strobe, then an idle cycle
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(posedge clock);
    #1 mem_wr = 1'b0;
    @(posedge clock);
    #1;
  endtask

  // One-cycle read strobe; data is registered on that edge
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    mem_addr = a;
    mem_rd = 1'b1;
    @(posedge clock);
    #1 mem_rd = 1'b0;
    d = mem_rdata;
    @(posedge clock);
    #1;
  endtask

  // Pull one port A pin low and record wake_req over six cycles
  task automatic wake_try(input int bit_n, input logic [7:0] exp);
    logic [7:0] seen;
    seen = 8'h00;
    a_val[bit_n] = 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      #1 seen[i] = wake_req;
    end
    check("wake_req", seen, exp);
    a_val = 8'hFF;
    repeat (6) @(posedge clock);
    #1;
  endtask

  // Watchdog for a hung run
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    #1;
    check("pa_out_rst", pa_out, RST_DATA);
    check("pa_oe_rst", pa_oe, 8'h00);
    check("pa_pu_rst", pa_pu, RST_PULLUP);
    check("rdata_rst", mem_rdata, RST_RDATA);
    check("pd_out_rst", {1'b0, pd_out}, 8'h7F);
    arst_n = 1'b1;
    @(posedge clock);
    #1;
    for (int i = 0; i < 9; i++) begin
      reg_rd(ADR[i], rd);
      check("reset_value", rd, RV[i]);
      reg_wr(ADR[i], 8'hA5);
      reg_rd(ADR[i], rd);
      check("readback", rd, (ADR[i] > 8'h0C) ? 8'h25 : 8'hA5);
    end
    reg_wr(8'h07, 8'hFF);
    reg_rd(8'h07, rd);
    check("unmapped", rd, 8'h00);
    // All ports as outputs; latch shows on pins, not the pin level
    foreach (ADR[i]) if (ADR[i][0]) reg_wr(ADR[i], 8'h00);
    reg_wr(OFS_PORT_A_DATA, 8'h55);
    reg_wr(OFS_PORT_B_DATA, 8'h3C);
    reg_wr(OFS_PORT_D_DATA, 8'hFF);
    a_drv = 8'hFF;
    a_val = 8'hAA;
    reg_rd(OFS_PORT_A_DATA, rd);
    check("out_read", rd, 8'h55);
    reg_rd(OFS_PORT_D_DATA, rd);
    check("pd_read", rd, 8'h7F);
    check("pa_out", pa_out, 8'h55);
    check("pa_oe", pa_oe, 8'hFF);
    check("pb_oe", pb_oe, 8'hFF);
    check("pd_oe", {1'b0, pd_oe}, 8'h7F);
    reg_rd(OFS_PORT_B_DATA, rd);
    check("pb_read", rd, 8'h3C);
    reg_wr(OFS_PORT_C_DATA, 8'h81);
    check("pb_out", pb_out, 8'h3C);
    check("pc_out", pc_out, 8'h81);
    // Live input reads with no input latch, then mixed direction
    reg_wr(OFS_PORT_A_DIRECTION, 8'hFF);
    a_val = 8'hA5;
    reg_rd(OFS_PORT_A_DATA, rd);
    check("live_in1", rd, 8'hA5);
    a_val = 8'h5A;
    reg_rd(OFS_PORT_A_DATA, rd);
    check("live_in2", rd, 8'h5A);
    reg_wr(OFS_PORT_A_DIRECTION, 8'h0F);
    a_val = 8'hC3;
    reg_rd(OFS_PORT_A_DATA, rd);
    check("mixed_in", rd, 8'h53);
    // Pull-up only on input pins
    reg_wr(OFS_PORT_C_DIRECTION, 8'hFF);
    reg_wr(OFS_PORT_C_PULLUP_ENABLE, 8'h0F);
    check("pc_pu_in", pc_pu, 8'h0F);
    reg_rd(OFS_PORT_C_DATA, rd);
    check("pulled_hi", rd & 8'h0F, 8'h0F);
    reg_wr(OFS_PORT_C_DIRECTION, 8'h3C);
    check("pc_pu_mix", pc_pu, 8'h0C);
    // Wake-up on falling edges of port A pins
    reg_wr(OFS_PORT_A_DIRECTION, 8'hFF);
    a_val = 8'hFF;
    reg_wr(OFS_PORT_A_WAKE_ENABLE, 8'h01);
    core_standby = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    wake_try(0, 8'h04);
    wake_try(1, 8'h00);
    core_standby = 1'b0;
    wake_try(0, 8'h00);
    core_standby = 1'b1;
    reg_wr(OFS_PORT_A_DIRECTION, 8'hFE);
    wake_try(0, 8'h00);
    reg_wr(OFS_PORT_A_DIRECTION, 8'hFF);
    reg_wr(OFS_PORT_A_WAKE_ENABLE, 8'hFF);
    repeat (4) @(posedge clock);
    #1;
    wake_try(7, 8'h04);
    // Reset in mid-run returns every register to its reset value again
    core_standby = 1'b0;
    arst_n = 1'b0;
    @(posedge clock);
    #1;
    check("pa_oe_rst2", pa_oe, 8'h00);
    check("pc_out_rst2", pc_out, RST_DATA);
    check("wake_rst2", {7'h00, wake_req}, 8'h00);
    arst_n = 1'b1;
    @(posedge clock);
    #1;
    reg_rd(OFS_PORT_A_WAKE_ENABLE, rd);
    check("wake_en_rst2", rd, RST_WAKE);
    wrap_up();
  end
endmodule
